// *** logic/smc_pkg.sv ***
// package of constants and types for the sleep mode controller
// Contract
// - async timer keeps counting in power-save
// - timer event wakes only with mask, global enable
// - power-save stops all clocks except async clock
// - select 110 with crystal enters standby
// - standby equals power-down but oscillator runs
// - standby wake-up completes within six cycles
// - enabled converter stays enabled in sleep
// - converter off then on gives extended conversion
// - comparator off except idle and noise reduction
// - comparator reference request keeps reference on
// - fused brown-out detector stays active in sleep
// - reference powered only when some user needs it
// - kept reference valid at once after wake-up
// - enabled watchdog keeps running in sleep
// - input buffers off when io, converter clocks stop
// - control register at io 0x35, data 0x55
// - halt sleeps only when arm bit five set
// - bits 4:2 select the sleep mode
// - interrupt wake holds core four cycles past start-up; standby holds it one cycle past a five-cycle start-up
// - idle stops only cpu and flash clocks
// - noise reduction also stops io clock
// - reset during sleep wakes to reset vector
`default_nettype none
package smc_pkg;
  localparam logic [5:0] IO_ADDR_CTRL = 6'h35;
  localparam logic [7:0] DATA_OFS = 8'h20;
  localparam logic [7:0] DATA_ADDR_CTRL = 8'h55;
  localparam int BIT_ARM = 5;
  localparam int KIND_LSB = 2;
  localparam int KIND_MSB = 4;
  localparam logic [7:0] CTRL_WMASK = 8'h3C;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STANDBY_WAKE_CYC = 6;
  localparam int HALT_EXTRA_CYC = 4;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    SMC_IDLE = 3'h0,
    SMC_NOISE = 3'h1,
    SMC_PDOWN = 3'h2,
    SMC_PSAVE = 3'h3,
    SMC_RSV4 = 3'h4,
    SMC_RSV5 = 3'h5,
    SMC_STANDBY = 3'h6,
    SMC_RSV7 = 3'h7
  } smc_kind_t;

  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_SLEEP,
    SMC_WAKE
  } smc_phase_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
    logic async;
    logic osc;
  } smc_clocks_t;

  typedef struct packed {
    logic comparator;
    logic reference;
    logic brownout;
    logic watchdog;
    logic converter;
    logic inbuf;
    logic wake_inbuf;
  } smc_analog_t;
endpackage
`default_nettype wire

// *** logic/smc_wake_timer.sv ***
// wake-up delay counter of the sleep mode controller
`timescale 1ns/100ps
`default_nettype none
module smc_wake_timer (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // control
  input wire logic i_load,
  input wire logic [3:0] i_count,
  // status
  output logic o_done
);
  typedef struct packed {
    logic [3:0] cnt;
    logic busy;
  } smc_wt_state_t;
  smc_wt_state_t state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (i_load) begin
      state_nxt.cnt = i_count;
      state_nxt.busy = 1'b1;
    end else if (state_r.busy) begin
      if (state_r.cnt == smc_pkg::CNT_ONE || state_r.cnt == smc_pkg::CNT_ZERO) begin
        state_nxt.busy = 1'b0;
      end
      state_nxt.cnt = state_r.cnt - smc_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_done = state_r.busy && (state_r.cnt == smc_pkg::CNT_ONE || state_r.cnt == smc_pkg::CNT_ZERO);
endmodule // smc_wake_timer
`default_nettype wire

// *** logic/smc_sleep_ctrl.sv ***
// sleep mode controller: control register, clock gating, analog enables, wake-up
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // core register port: io space or data space
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [5:0] i_io_addr,
  input wire logic i_ds_wr,
  input wire logic i_ds_rd,
  input wire logic [7:0] i_ds_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_hit,
  // core halt handshake
  input wire logic i_halt_exec,
  output logic o_core_hold,
  output logic o_resume_next,
  output logic o_run_isr,
  // wake sources
  input wire logic i_ext_level_irq,
  input wire logic i_twi_match_irq,
  input wire logic i_conv_irq,
  input wire logic i_nvm_ready_irq,
  input wire logic i_other_io_irq,
  input wire logic i_timer_ovf_evt,
  input wire logic i_timer_cmp_evt,
  input wire logic i_timer_ovf_mask,
  input wire logic i_timer_cmp_mask,
  input wire logic i_global_irq_en,
  // configuration
  input wire logic i_async_timer_clock_select,
  input wire logic i_crystal_clock,
  input wire logic i_brownout_fuse,
  input wire logic i_watchdog_en,
  input wire logic i_converter_en,
  input wire logic i_comparator_en,
  input wire logic i_comparator_use_ref,
  input wire logic [3:0] i_startup_cycles,
  // gating outputs
  output smc_pkg::smc_clocks_t o_clk_en,
  output smc_pkg::smc_analog_t o_analog_en,
  output logic o_ref_ready,
  output logic o_conv_extended
);
  // reference start-up in cycles (arbitrary default)
  localparam logic [3:0] REF_STARTUP_CYC = 4'h8;
  localparam logic [3:0] STANDBY_CNT = 4'(smc_pkg::STANDBY_WAKE_CYC - 1);
  localparam logic [3:0] EXTRA_CNT = 4'(smc_pkg::HALT_EXTRA_CYC);

  typedef struct packed {
    logic [7:0] ctrl;
    smc_pkg::smc_phase_t phase;
    smc_pkg::smc_kind_t kind;
    logic irq_wake;
    logic hold_extra;
    logic [3:0] extra_cnt;
    logic [3:0] ref_cnt;
    logic conv_prev;
    logic conv_ext;
    logic [1:0][2:0] evt_sync;
    logic [1:0] evt_seen;
    smc_pkg::smc_clocks_t clk;
    smc_pkg::smc_analog_t ana;
    logic [7:0] rdata;
    logic rhit;
    logic resume;
    logic isr;
  } smc_state_t;
  smc_state_t s_r, s_nxt;

  logic wt_done;
  logic wt_load;
  logic [3:0] wt_count;

  function automatic logic ctrl_sel(input logic io_en, input logic [5:0] io_a,
                                    input logic ds_en, input logic [7:0] ds_a);
    ctrl_sel = (io_en && io_a == smc_pkg::IO_ADDR_CTRL) ||
               (ds_en && ds_a == smc_pkg::DATA_ADDR_CTRL);
  endfunction

  // legal kinds only; reserved codes and standby without crystal leave the core running
  function automatic logic kind_legal(input smc_pkg::smc_kind_t k, input logic xtal);
    unique case (k)
      smc_pkg::SMC_IDLE, smc_pkg::SMC_NOISE, smc_pkg::SMC_PDOWN, smc_pkg::SMC_PSAVE: kind_legal = 1'b1;
      smc_pkg::SMC_STANDBY: kind_legal = xtal;
      default: kind_legal = 1'b0;
    endcase
  endfunction

  function automatic smc_pkg::smc_clocks_t sleep_clocks(input smc_pkg::smc_kind_t k, input logic as_sel);
    smc_pkg::smc_clocks_t c;
    c = '0;
    unique case (k)
      smc_pkg::SMC_IDLE: begin
        c.io = 1'b1;
        c.conv = 1'b1;
        c.async = 1'b1;
        c.osc = 1'b1;
      end
      smc_pkg::SMC_NOISE: begin
        c.conv = 1'b1;
        c.async = 1'b1;
        c.osc = 1'b1;
      end
      smc_pkg::SMC_PSAVE: c.async = as_sel;
      smc_pkg::SMC_STANDBY: c.osc = 1'b1;
      default: c = '0;
    endcase
    sleep_clocks = c;
  endfunction

  logic sel_wr, sel_rd, timer_wake, any_wake, kind_can_timer, ref_need;
  smc_pkg::smc_kind_t cur_kind;

  always_comb begin
    sel_wr = ctrl_sel(i_io_wr, i_io_addr, i_ds_wr, i_ds_addr);
    sel_rd = ctrl_sel(i_io_rd, i_io_addr, i_ds_rd, i_ds_addr);
    cur_kind = smc_pkg::smc_kind_t'(s_r.ctrl[smc_pkg::KIND_MSB:smc_pkg::KIND_LSB]);
    kind_can_timer = (s_r.kind == smc_pkg::SMC_IDLE) || (s_r.kind == smc_pkg::SMC_NOISE) ||
                     (s_r.kind == smc_pkg::SMC_PSAVE && i_async_timer_clock_select);
    timer_wake = kind_can_timer && i_global_irq_en &&
                 ((s_r.evt_seen[0] && i_timer_ovf_mask) || (s_r.evt_seen[1] && i_timer_cmp_mask));
    unique case (s_r.kind)
      smc_pkg::SMC_IDLE: any_wake = i_ext_level_irq || i_twi_match_irq || i_conv_irq ||
                                     i_nvm_ready_irq || i_other_io_irq || timer_wake;
      smc_pkg::SMC_NOISE: any_wake = i_ext_level_irq || i_twi_match_irq || i_conv_irq ||
                                      i_nvm_ready_irq || timer_wake;
      default: any_wake = i_ext_level_irq || i_twi_match_irq || timer_wake;
    endcase

    s_nxt = s_r;
    s_nxt.resume = 1'b0;
    s_nxt.isr = 1'b0;
    wt_load = 1'b0;
    wt_count = i_startup_cycles;
    // timer events come from the async clock: three flops, a level counts once the last two agree
    s_nxt.evt_sync[0] = {s_r.evt_sync[0][1:0], i_timer_ovf_evt};
    s_nxt.evt_sync[1] = {s_r.evt_sync[1][1:0], i_timer_cmp_evt};
    for (int e = 0; e < 2; e++) begin
      if (s_r.evt_sync[e][1] == s_r.evt_sync[e][2]) begin
        s_nxt.evt_seen[e] = s_r.evt_sync[e][2];
      end
    end
    if (sel_wr) begin
      s_nxt.ctrl = i_wdata & smc_pkg::CTRL_WMASK;
    end
    s_nxt.rhit = sel_rd;
    s_nxt.rdata = sel_rd ? s_r.ctrl : 8'h00;

    unique case (s_r.phase)
      smc_pkg::SMC_RUN: begin
        if (i_halt_exec) begin
          if (s_r.ctrl[smc_pkg::BIT_ARM] && kind_legal(cur_kind, i_crystal_clock)) begin
            s_nxt.phase = smc_pkg::SMC_SLEEP;
            s_nxt.kind = cur_kind;
          end else begin
            s_nxt.resume = 1'b1;
          end
        end
      end
      smc_pkg::SMC_SLEEP: begin
        if (any_wake) begin
          s_nxt.phase = smc_pkg::SMC_WAKE;
          s_nxt.irq_wake = 1'b1;
          s_nxt.hold_extra = 1'b0;
          wt_load = 1'b1;
          unique case (s_r.kind)
            smc_pkg::SMC_IDLE, smc_pkg::SMC_NOISE: wt_count = smc_pkg::CNT_ONE;
            smc_pkg::SMC_STANDBY: wt_count = STANDBY_CNT;
            default: wt_count = i_startup_cycles;
          endcase
        end
      end
      smc_pkg::SMC_WAKE: begin
        if (!s_r.hold_extra && wt_done) begin
          s_nxt.hold_extra = 1'b1;
          s_nxt.extra_cnt = EXTRA_CNT;
          if (s_r.kind == smc_pkg::SMC_STANDBY) begin
            s_nxt.extra_cnt = smc_pkg::CNT_ZERO;
          end
        end else if (s_r.hold_extra) begin
          if (s_r.extra_cnt <= smc_pkg::CNT_ONE) begin
            s_nxt.phase = smc_pkg::SMC_RUN;
            s_nxt.hold_extra = 1'b0;
            s_nxt.isr = s_r.irq_wake;
            s_nxt.irq_wake = 1'b0;
          end else begin
            s_nxt.extra_cnt = s_r.extra_cnt - smc_pkg::CNT_ONE;
          end
        end
      end
      default: s_nxt.phase = smc_pkg::SMC_RUN;
    endcase

    // clocks are gated only in SLEEP; in RUN and WAKE every clock runs, and in WAKE the core is held
    if (s_nxt.phase == smc_pkg::SMC_SLEEP) begin
      s_nxt.clk = sleep_clocks(s_nxt.kind, i_async_timer_clock_select);
    end else begin
      s_nxt.clk = '1;
    end

    s_nxt.ana.converter = i_converter_en;
    s_nxt.ana.watchdog = i_watchdog_en;
    s_nxt.ana.brownout = i_brownout_fuse;
    s_nxt.ana.comparator = i_comparator_en && (s_nxt.phase != smc_pkg::SMC_SLEEP ||
                           s_nxt.kind == smc_pkg::SMC_IDLE || s_nxt.kind == smc_pkg::SMC_NOISE);
    // a comparator wired to the reference keeps it powered even while the comparator itself is off
    ref_need = i_brownout_fuse || i_converter_en || i_comparator_use_ref;
    s_nxt.ana.reference = ref_need;
    s_nxt.ana.inbuf = !(s_nxt.phase == smc_pkg::SMC_SLEEP && !s_nxt.clk.io && !s_nxt.clk.conv);
    s_nxt.ana.wake_inbuf = 1'b1;

    // reference keeps its ready state while powered, sleep or not
    if (!ref_need) begin
      s_nxt.ref_cnt = REF_STARTUP_CYC;
    end else if (s_r.ref_cnt != smc_pkg::CNT_ZERO) begin
      s_nxt.ref_cnt = s_r.ref_cnt - smc_pkg::CNT_ONE;
    end

    s_nxt.conv_prev = i_converter_en;
    if (i_converter_en && !s_r.conv_prev) begin
      s_nxt.conv_ext = 1'b1;
    end else if (i_conv_irq) begin
      s_nxt.conv_ext = 1'b0;
    end
  end

  smc_wake_timer u_wake_timer (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_load(wt_load),
    .i_count(wt_count),
    .o_done(wt_done)
  );

  // reset in any phase returns to RUN with the core restarted from its reset vector
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.clk <= '1;
      s_r.ref_cnt <= REF_STARTUP_CYC;
      s_r.conv_ext <= 1'b1;
      s_r.ana.inbuf <= 1'b1;
      s_r.ana.wake_inbuf <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_rdata_hit = s_r.rhit;
  assign o_core_hold = (s_r.phase != smc_pkg::SMC_RUN);
  assign o_resume_next = s_r.resume;
  assign o_run_isr = s_r.isr;
  assign o_clk_en = s_r.clk;
  assign o_analog_en = s_r.ana;
  assign o_ref_ready = s_r.ana.reference && (s_r.ref_cnt == smc_pkg::CNT_ZERO);
  assign o_conv_extended = s_r.conv_ext;

  property p_halt_unarmed;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_RUN && i_halt_exec && !s_r.ctrl[smc_pkg::BIT_ARM]) |=> (o_resume_next && !o_core_hold);
  endproperty
  a_halt_unarmed: assert property (p_halt_unarmed) else $error("unarmed halt slept");

  property p_halt_armed;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_RUN && i_halt_exec && s_r.ctrl[smc_pkg::BIT_ARM] &&
       cur_kind == smc_pkg::SMC_PDOWN) |=> (o_core_hold && o_clk_en == '0);
  endproperty
  a_halt_armed: assert property (p_halt_armed) else $error("armed power-down not entered");

  property p_idle_clocks;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_SLEEP && s_r.kind == smc_pkg::SMC_IDLE) |->
        (!o_clk_en.cpu && !o_clk_en.flash && o_clk_en.io && o_clk_en.conv);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock set wrong");

  property p_psave_async;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_SLEEP && s_r.kind == smc_pkg::SMC_PSAVE) |->
        (o_clk_en.async == i_async_timer_clock_select && !o_clk_en.io && !o_clk_en.osc);
  endproperty
  a_psave_async: assert property (p_psave_async) else $error("power-save clocks wrong");

  sequence s_standby_wake;
    s_r.phase == smc_pkg::SMC_SLEEP && s_r.kind == smc_pkg::SMC_STANDBY && any_wake;
  endsequence
  property p_standby_wake;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_standby_wake |-> ##[1:6] (s_r.phase == smc_pkg::SMC_WAKE && s_r.hold_extra);
  endproperty
  a_standby_wake: assert property (p_standby_wake) else $error("standby wake too slow");

  property p_timer_gate;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_SLEEP && s_r.kind == smc_pkg::SMC_PSAVE && !i_global_irq_en &&
       !i_ext_level_irq && !i_twi_match_irq) |=> (s_r.phase == smc_pkg::SMC_SLEEP);
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer woke without enable");

  property p_comp_off;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_SLEEP && s_r.kind != smc_pkg::SMC_IDLE &&
       s_r.kind != smc_pkg::SMC_NOISE) |-> !o_analog_en.comparator;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("comparator on in deep sleep");

  property p_inbuf;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_SLEEP && s_r.kind == smc_pkg::SMC_PDOWN) |->
        (!o_analog_en.inbuf && o_analog_en.wake_inbuf);
  endproperty
  a_inbuf: assert property (p_inbuf) else $error("input buffers on in power-down");

  property p_ref_follow;
    @(posedge i_clock) disable iff (i_sys_rst)
      $changed(ref_need) |=> (o_analog_en.reference == $past(ref_need));
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference enable lags need");

  property p_conv_ext;
    @(posedge i_clock) disable iff (i_sys_rst)
      $rose(i_converter_en) |=> o_conv_extended;
  endproperty
  a_conv_ext: assert property (p_conv_ext) else $error("extended conversion missed");

  property p_standby_entry;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_RUN && i_halt_exec && s_r.ctrl[smc_pkg::BIT_ARM] &&
       cur_kind == smc_pkg::SMC_STANDBY && i_crystal_clock) |=> (o_core_hold && o_clk_en.osc && !o_clk_en.io);
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");

  property p_reserved_kind;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_r.phase == smc_pkg::SMC_RUN && i_halt_exec && (cur_kind == smc_pkg::SMC_RSV4 ||
       cur_kind == smc_pkg::SMC_RSV5 || cur_kind == smc_pkg::SMC_RSV7)) |=> (o_resume_next && !o_core_hold);
  endproperty
  a_reserved_kind: assert property (p_reserved_kind) else $error("reserved kind slept");
endmodule // smc_sleep_ctrl
`default_nettype wire

// *** verification/tb_sleep_mode_controller.sv ***
// self-checking testbench of the sleep mode controller
`timescale 1ns/100ps
`default_nettype none
module tb_sleep_mode_controller;
  logic i_clock, i_sys_rst, i_io_wr, i_io_rd, i_ds_wr, i_ds_rd, i_halt_exec;
  logic [5:0] i_io_addr;
  logic [7:0] i_ds_addr, i_wdata, o_rdata;
  logic o_rdata_hit, o_core_hold, o_resume_next, o_run_isr, o_ref_ready, o_conv_extended;
  logic i_ext_level_irq, i_conv_irq, i_timer_ovf_evt, i_timer_ovf_mask, i_timer_cmp_mask, i_global_irq_en;
  logic i_async_timer_clock_select, i_crystal_clock, i_brownout_fuse, i_watchdog_en;
  logic i_converter_en, i_comparator_en, i_comparator_use_ref;
  logic [3:0] i_startup_cycles;
  smc_pkg::smc_clocks_t o_clk_en;
  smc_pkg::smc_analog_t o_analog_en;
  logic rd_taken;
  logic [8:0] rd_q[$];
  logic [8:0] rd_exp;
  logic [31:0] cfg;
  logic [5:0] exp_clk;
  logic ref_on;
  int num_errors, num_checks, seed, k, n;

  smc_sleep_ctrl u_smc_sleep_ctrl (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_addr(i_io_addr),
    .i_ds_wr(i_ds_wr), .i_ds_rd(i_ds_rd), .i_ds_addr(i_ds_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_hit(o_rdata_hit),
    .i_halt_exec(i_halt_exec), .o_core_hold(o_core_hold),
    .o_resume_next(o_resume_next), .o_run_isr(o_run_isr),
    .i_ext_level_irq(i_ext_level_irq), .i_twi_match_irq(1'h0), .i_conv_irq(i_conv_irq),
    .i_nvm_ready_irq(1'h0), .i_other_io_irq(1'h0),
    .i_timer_ovf_evt(i_timer_ovf_evt), .i_timer_cmp_evt(1'h0),
    .i_timer_ovf_mask(i_timer_ovf_mask), .i_timer_cmp_mask(i_timer_cmp_mask),
    .i_global_irq_en(i_global_irq_en),
    .i_async_timer_clock_select(i_async_timer_clock_select),
    .i_crystal_clock(i_crystal_clock), .i_brownout_fuse(i_brownout_fuse),
    .i_watchdog_en(i_watchdog_en), .i_converter_en(i_converter_en),
    .i_comparator_en(i_comparator_en), .i_comparator_use_ref(i_comparator_use_ref),
    .i_startup_cycles(i_startup_cycles),
    .o_clk_en(o_clk_en), .o_analog_en(o_analog_en),
    .o_ref_ready(o_ref_ready), .o_conv_extended(o_conv_extended)
  );

  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ds selects data space, otherwise the low six address bits go to io space
  task automatic wr(input logic ds, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_io_wr = !ds;
    i_ds_wr = ds;
    i_io_addr = a[5:0];
    i_ds_addr = a;
    i_wdata = d;
    @(negedge i_clock);
    i_io_wr = 1'h0;
    i_ds_wr = 1'h0;
  endtask

  // expectation is {hit, data}; the monitor below does the compare
  task automatic rd(input logic ds, input logic [7:0] a, input logic [8:0] e);
    @(negedge i_clock);
    i_io_rd = !ds;
    i_ds_rd = ds;
    i_io_addr = a[5:0];
    i_ds_addr = a;
    rd_q.push_back(e);
    @(negedge i_clock);
    i_io_rd = 1'h0;
    i_ds_rd = 1'h0;
  endtask

  task automatic halt();
    @(negedge i_clock);
    i_halt_exec = 1'h1;
    @(negedge i_clock);
    i_halt_exec = 1'h0;
  endtask

  // counts negedges until the core hold drops, bounded so a stuck hold cannot hang the run
  task automatic wait_release();
    k = 1;
    while (o_core_hold === 1'h1 && k < 40) begin
      @(negedge i_clock);
      k++;
    end
  endtask

  function automatic logic [5:0] clocks_for(input logic [2:0] m, input logic asy);
    case (m)
      3'h0: return 6'h0F;
      3'h1: return 6'h07;
      3'h3: return {4'h0, asy, 1'h0};
      3'h6: return 6'h01;
      default: return 6'h00;
    endcase
  endfunction

  always @(posedge i_clock) rd_taken <= i_io_rd | i_ds_rd;

  always @(negedge i_clock) begin
    if (rd_taken === 1'h1) begin
      rd_exp = rd_q.pop_front();
      check({o_rdata_hit, o_rdata} === rd_exp, "register read");
    end else if (o_rdata_hit !== 1'h0) begin
      check(1'h0, "read hit without a read");
    end
  end

  initial begin
    repeat (5000) @(posedge i_clock);
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test();
  end

  initial begin
    seed = 32'hBAF8;
    {i_io_wr, i_io_rd, i_ds_wr, i_ds_rd, i_halt_exec, i_ext_level_irq, i_conv_irq} = 7'h00;
    {i_timer_ovf_evt, i_timer_ovf_mask, i_timer_cmp_mask, i_global_irq_en, i_async_timer_clock_select} = 5'h00;
    {i_brownout_fuse, i_watchdog_en, i_converter_en, i_comparator_en} = 4'h0;
    i_comparator_use_ref = 1'h0;
    i_crystal_clock = 1'h1;
    i_io_addr = 6'h00;
    i_ds_addr = 8'h00;
    i_wdata = 8'h00;
    i_startup_cycles = 4'h3;
    i_sys_rst = 1'h1;
    repeat (3) @(negedge i_clock);
    i_sys_rst = 1'h0;
    rd(1'h0, 8'h35, 9'h100);
    wr(1'h0, 8'h35, 8'hFF);
    rd(1'h0, 8'h35, 9'h13C);
    rd(1'h1, 8'h55, 9'h13C);
    rd(1'h0, 8'h15, 9'h000);
    rd(1'h1, 8'h35, 9'h000);
    wr(1'h1, 8'h55, 8'h00);
    wr(1'h0, 8'h36, 8'hFF);
    rd(1'h0, 8'h35, 9'h100);
    // converter off then on must mark the next conversion extended
    i_converter_en = 1'h1;
    @(negedge i_clock);
    i_conv_irq = 1'h1;
    @(negedge i_clock);
    i_conv_irq = 1'h0;
    @(negedge i_clock);
    check(o_conv_extended === 1'h0, "extended flag clear");
    i_converter_en = 1'h0;
    repeat (3) @(negedge i_clock);
    i_converter_en = 1'h1;
    repeat (3) @(negedge i_clock);
    check(o_conv_extended === 1'h1, "extended after power cycle");
    wr(1'h0, 8'h35, 8'h0C);
    halt();
    check(o_resume_next === 1'h1 && o_core_hold === 1'h0, "unarmed halt");
    i_crystal_clock = 1'h0;
    wr(1'h0, 8'h35, 8'h38);
    halt();
    check(o_resume_next === 1'h1 && o_core_hold === 1'h0, "standby without crystal");
    i_crystal_clock = 1'h1;
    for (int m = 0; m < 8; m++) begin
      cfg = $random(seed);
      {i_comparator_use_ref, i_comparator_en, i_converter_en} = cfg[5:3];
      {i_watchdog_en, i_brownout_fuse, i_async_timer_clock_select} = cfg[2:0];
      i_startup_cycles = cfg[9:6];
      ref_on = cfg[1] | cfg[3] | cfg[5];
      exp_clk = clocks_for(m[2:0], cfg[0]);
      // reference needs its start-up time before sleep for the reference ready check after wake-up
      repeat (12) @(negedge i_clock);
      wr(1'h0, 8'h35, {2'h0, 1'h1, m[2:0], 2'h0});
      halt();
      if (m inside {4, 5, 7}) begin
        check(o_resume_next === 1'h1 && o_core_hold === 1'h0, "reserved kind");
      end else begin
        check(o_core_hold === 1'h1, "halt hold");
        check(o_clk_en === exp_clk, "gated clocks");
        check(o_analog_en.comparator === (m < 2 && cfg[4]), "comparator");
        check(o_analog_en.reference === ref_on, "reference");
        check({o_analog_en.converter, o_analog_en.watchdog, o_analog_en.brownout} === cfg[3:1],
              "kept modules");
        check(o_analog_en.inbuf === (exp_clk[3] | exp_clk[2]), "input buffers");
        i_ext_level_irq = 1'h1;
        @(negedge i_clock);
        check(o_clk_en === 6'h3F, "clocks restart");
        wait_release();
        n = (m < 2 || i_startup_cycles < 4'h2) ? 1 : int'(i_startup_cycles);
        if (m == 6) check(k <= 7, "standby wake time");
        else check(k >= n + 5 && k <= n + 8, "wake hold time");
        check(o_run_isr === 1'h1, "handler start");
        check(!ref_on || o_ref_ready === 1'h1, "reference ready");
        i_ext_level_irq = 1'h0;
      end
    end
    // async timer event wakes power-save only with its own mask and global enable
    i_async_timer_clock_select = 1'h1;
    i_global_irq_en = 1'h1;
    i_timer_cmp_mask = 1'h1;
    wr(1'h0, 8'h35, 8'h2C);
    halt();
    i_timer_ovf_evt = 1'h1;
    repeat (6) @(negedge i_clock);
    check(o_core_hold === 1'h1, "timer event under the other mask");
    i_timer_ovf_mask = 1'h1;
    i_global_irq_en = 1'h0;
    repeat (6) @(negedge i_clock);
    check(o_core_hold === 1'h1, "timer event without global enable");
    i_global_irq_en = 1'h1;
    @(negedge i_clock);
    wait_release();
    check(o_core_hold === 1'h0 && o_run_isr === 1'h1, "timer wake");
    i_timer_ovf_evt = 1'h0;
    wr(1'h0, 8'h35, 8'h28);
    halt();
    check(o_core_hold === 1'h1, "power-down entry");
    @(negedge i_clock);
    i_sys_rst = 1'h1;
    @(negedge i_clock);
    i_sys_rst = 1'h0;
    check(o_core_hold === 1'h0 && o_clk_en === 6'h3F, "reset wakes");
    rd(1'h0, 8'h35, 9'h100);
    repeat (3) @(negedge i_clock);
    end_of_test();
  end
endmodule // tb_sleep_mode_controller
`default_nettype wire
